//--- core/eeprom_access_port.sv
// software access port to the external serial configuration eeprom
//
// Function
// R01 - start bit launches one eeprom access
// R02 - command bit: zero read, one write
// R03 - error flag set on missing acknowledge
// R04 - autoload success bit, cleared on read
// R05 - autoload status bit, sticky until reset
// R06 - autoload inhibit bit, resets to one
// R07 - serial clock divided from core, rate field
// R08 - eeprom location from bits 15:9
// R09 - write sends data field to eeprom
// R10 - read completion loads data field
// R11 - start clears at end; software polls it
// R12 - two-wire protocol, ack after every byte; the port refuses the low byte of a read
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_port (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ,
   output logic EE_SCL,
   input wire logic EE_SDA_IN,
   output logic EE_SDA_OUT,
   output logic EE_SDA_OE_N,
   input wire logic AUTOLOAD_DONE,
   input wire logic AUTOLOAD_OK,
   output logic AUTOLOAD_ENABLE
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic rst_n;
   logic tick;
   logic start_r, start_nxt;
   logic cmd_r, cmd_nxt;
   logic err_r, err_nxt;
   logic aok_r, aok_nxt;
   logic astat_r, astat_nxt;
   logic adis_r, adis_nxt;
   logic [1:0] rate_r, rate_nxt;
   logic [6:0] loc_r, loc_nxt;
   logic [15:0] data_r, data_nxt;
   logic [eeprom_pkg::IRQ_W-1:0] ist_r, ist_nxt;
   logic [eeprom_pkg::IRQ_W-1:0] ien_r, ien_nxt;
   logic [eeprom_pkg::IRQ_W-1:0] ev;
   logic irq_r, irq_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic aen_r, aen_nxt;
   logic [31:0] access_word;
   logic wr_access;
   logic aload_hit;
   eeprom_pkg::xfer_e st_r, st_nxt;
   logic [1:0] q_r, q_nxt;
   logic [2:0] bc_r, bc_nxt;
   logic [2:0] step_r, step_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] rhi_r, rhi_nxt;
   logic nack_r, nack_nxt;
   logic scl_r, scl_nxt;
   logic rel_r, rel_nxt;
   logic sda_out_r;
   logic done_ev;
   logic err_ev;
   logic ld_ev;

   // ----------------------------------------------------------------
   // reset release and quarter tick
   // ----------------------------------------------------------------
   eeprom_rst_sync u_rst (
      .clk(CLK),
      .rst_n(RST_N),
      .rst_sync_n(rst_n)
   );

   // R07 serial clock divider
   eeprom_qtr_tick u_tick (
      .clk(CLK),
      .rst_n(rst_n),
      .rate(rate_r),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // assembled access word as software sees it
   always_comb begin
      access_word = 32'h0000_0000;
      access_word[eeprom_pkg::START_BIT] = start_r;
      access_word[eeprom_pkg::CMD_BIT] = cmd_r;
      access_word[eeprom_pkg::ERR_BIT] = err_r;
      access_word[eeprom_pkg::ALOAD_OK_BIT] = aok_r;
      access_word[eeprom_pkg::ALOAD_STAT_BIT] = astat_r;
      access_word[eeprom_pkg::ALOAD_DIS_BIT] = adis_r;
      access_word[eeprom_pkg::RATE_MSB:eeprom_pkg::RATE_LSB] = rate_r;
      access_word[eeprom_pkg::RSVD_BIT] = 1'b0;
      access_word[eeprom_pkg::LOC_MSB:eeprom_pkg::LOC_LSB] = loc_r;
      access_word[eeprom_pkg::DATA_MSB:eeprom_pkg::DATA_LSB] = data_r;
   end

   // next values of the software-visible state
   always_comb begin
      // writes to the access word are ignored while an access runs
      wr_access = WR && (ADDR == eeprom_pkg::OFS_ACCESS) && !start_r;
      aload_hit = AUTOLOAD_DONE && AUTOLOAD_OK && aen_r;
      start_nxt = start_r;
      cmd_nxt = cmd_r;
      err_nxt = err_r;
      aok_nxt = aok_r;
      astat_nxt = astat_r;
      adis_nxt = adis_r;
      rate_nxt = rate_r;
      loc_nxt = loc_r;
      data_nxt = data_r;
      ien_nxt = ien_r;
      if (wr_access) begin
         // R01 start on write one
         start_nxt = WDATA[eeprom_pkg::START_BIT];
         // R02 access kind
         cmd_nxt = WDATA[eeprom_pkg::CMD_BIT];
         // R06 inhibit bit
         adis_nxt = WDATA[eeprom_pkg::ALOAD_DIS_BIT];
         // R07 rate field
         rate_nxt = WDATA[eeprom_pkg::RATE_MSB:eeprom_pkg::RATE_LSB];
         // R08 target location
         loc_nxt = WDATA[eeprom_pkg::LOC_MSB:eeprom_pkg::LOC_LSB];
         data_nxt = WDATA[eeprom_pkg::DATA_MSB:eeprom_pkg::DATA_LSB];
         if (WDATA[eeprom_pkg::START_BIT]) begin
            err_nxt = 1'b0; // fresh access, fresh error flag
         end
      end
      // R11 start clears at end
      if (done_ev) begin
         start_nxt = 1'b0;
      end
      // R03 missing acknowledge
      if (err_ev) begin
         err_nxt = 1'b1;
      end
      // R10 read word returned
      if (ld_ev) begin
         data_nxt = {rhi_r, sh_r};
      end
      // R04 clear on read, set wins
      if (RD && (ADDR == eeprom_pkg::OFS_ACCESS)) begin
         aok_nxt = 1'b0;
      end
      if (aload_hit) begin
         aok_nxt = 1'b1;
      end
      // R05 sticky autoload status
      if (aload_hit) begin
         astat_nxt = 1'b1;
      end
      if (WR && (ADDR == eeprom_pkg::OFS_IRQ_ENABLE)) begin
         ien_nxt = WDATA[eeprom_pkg::IRQ_W-1:0];
      end
      // R06 inhibit steers the loader
      aen_nxt = !adis_r;
   end

   // interrupt status: events set, write-one clears, set wins
   always_comb begin
      ev = '0;
      ev[eeprom_pkg::IRQ_DONE] = done_ev;
      ev[eeprom_pkg::IRQ_ERR] = err_ev;
      ev[eeprom_pkg::IRQ_ALOAD] = aload_hit;
      ist_nxt = ist_r;
      if (WR && (ADDR == eeprom_pkg::OFS_IRQ_CLEAR)) begin
         ist_nxt = ist_r & ~WDATA[eeprom_pkg::IRQ_W-1:0];
      end
      ist_nxt = ist_nxt | ev;
      irq_nxt = |(ist_nxt & ien_nxt);
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (RD) begin
         case (ADDR)
            eeprom_pkg::OFS_ACCESS: rdata_nxt = access_word;
            eeprom_pkg::OFS_IRQ_STATUS: rdata_nxt[eeprom_pkg::IRQ_W-1:0] = ist_r;
            eeprom_pkg::OFS_IRQ_ENABLE: rdata_nxt[eeprom_pkg::IRQ_W-1:0] = ien_r;
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // register file flops
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         start_r <= 1'b0;
         cmd_r <= 1'b0;
         err_r <= 1'b0;
         aok_r <= 1'b0;
         astat_r <= 1'b0;
         adis_r <= eeprom_pkg::ALOAD_DIS_RST;
         rate_r <= eeprom_pkg::RATE_RST;
         loc_r <= eeprom_pkg::LOC_RST;
         data_r <= eeprom_pkg::DATA_RST;
         ist_r <= '0;
         ien_r <= '0;
         irq_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         aen_r <= 1'b0;
      end else begin
         start_r <= start_nxt;
         cmd_r <= cmd_nxt;
         err_r <= err_nxt;
         aok_r <= aok_nxt;
         astat_r <= astat_nxt;
         adis_r <= adis_nxt;
         rate_r <= rate_nxt;
         loc_r <= loc_nxt;
         data_r <= data_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= irq_nxt;
         rdata_r <= rdata_nxt;
         aen_r <= aen_nxt;
      end
   end

   // ----------------------------------------------------------------
   // two-wire serial engine
   // ----------------------------------------------------------------
   // R12 byte and bit sequencing
   always_comb begin
      st_nxt = st_r;
      q_nxt = q_r;
      bc_nxt = bc_r;
      step_nxt = step_r;
      sh_nxt = sh_r;
      rhi_nxt = rhi_r;
      nack_nxt = nack_r;
      scl_nxt = scl_r;
      rel_nxt = rel_r;
      done_ev = 1'b0;
      err_ev = 1'b0;
      ld_ev = 1'b0;
      if (st_r == eeprom_pkg::XF_IDLE) begin
         scl_nxt = 1'b1;
         rel_nxt = 1'b1;
         if (start_r) begin
            st_nxt = eeprom_pkg::XF_START;
            q_nxt = eeprom_pkg::Q0;
            step_nxt = eeprom_pkg::STEP_CTRL;
            sh_nxt = {eeprom_pkg::DEV_SEL, 1'b0};
            bc_nxt = eeprom_pkg::BIT_FIRST;
            nack_nxt = 1'b0;
         end
      end else if (tick) begin
         q_nxt = q_r + 2'h1;
         case (st_r)
            eeprom_pkg::XF_START, eeprom_pkg::XF_RSTART: begin
               // data falls while clock is high
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = (st_r == eeprom_pkg::XF_START);
                     rel_nxt = 1'b1;
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: rel_nxt = 1'b0;
                  default: begin
                     scl_nxt = 1'b0;
                     st_nxt = eeprom_pkg::XF_BIT;
                     if (st_r == eeprom_pkg::XF_RSTART) begin
                        sh_nxt = {eeprom_pkg::DEV_SEL, 1'b1};
                        bc_nxt = eeprom_pkg::BIT_FIRST;
                        step_nxt = eeprom_pkg::STEP_CTRLR;
                     end
                  end
               endcase
            end
            eeprom_pkg::XF_BIT: begin
               // R09 shift out, msb first
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = 1'b0;
                     rel_nxt = sh_r[7];
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: scl_nxt = 1'b1;
                  default: begin
                     scl_nxt = 1'b0;
                     sh_nxt = {sh_r[6:0], 1'b0};
                     if (bc_r == eeprom_pkg::BIT_LAST) begin
                        st_nxt = eeprom_pkg::XF_ACK;
                     end else begin
                        bc_nxt = bc_r - 3'h1;
                     end
                  end
               endcase
            end
            eeprom_pkg::XF_ACK: begin
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = 1'b0;
                     rel_nxt = 1'b1;
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: begin
                     // R03 sample acknowledge
                     if (EE_SDA_IN) begin
                        nack_nxt = 1'b1;
                        err_ev = 1'b1;
                     end
                  end
                  default: begin
                     scl_nxt = 1'b0;
                     bc_nxt = eeprom_pkg::BIT_FIRST;
                     st_nxt = eeprom_pkg::XF_BIT;
                     if (nack_r) begin
                        st_nxt = eeprom_pkg::XF_STOP;
                     end else begin
                        case (step_r)
                           eeprom_pkg::STEP_CTRL: begin
                              // R08 send location
                              sh_nxt = {loc_r, 1'b0};
                              step_nxt = eeprom_pkg::STEP_ADDR;
                           end
                           eeprom_pkg::STEP_ADDR: begin
                              // R02 branch on access kind
                              if (cmd_r == eeprom_pkg::CMD_WRITE) begin
                                 sh_nxt = data_r[15:8];
                                 step_nxt = eeprom_pkg::STEP_DHI;
                              end else begin
                                 st_nxt = eeprom_pkg::XF_RSTART;
                              end
                           end
                           eeprom_pkg::STEP_DHI: begin
                              // R09 low data byte
                              sh_nxt = data_r[7:0];
                              step_nxt = eeprom_pkg::STEP_DLO;
                           end
                           eeprom_pkg::STEP_CTRLR: begin
                              st_nxt = eeprom_pkg::XF_RBIT;
                              step_nxt = eeprom_pkg::STEP_HI;
                           end
                           default: st_nxt = eeprom_pkg::XF_STOP;
                        endcase
                     end
                  end
               endcase
            end
            eeprom_pkg::XF_RBIT: begin
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = 1'b0;
                     rel_nxt = 1'b1;
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: sh_nxt = {sh_r[6:0], EE_SDA_IN};
                  default: begin
                     scl_nxt = 1'b0;
                     if (bc_r == eeprom_pkg::BIT_LAST) begin
                        st_nxt = eeprom_pkg::XF_MACK;
                     end else begin
                        bc_nxt = bc_r - 3'h1;
                     end
                  end
               endcase
            end
            eeprom_pkg::XF_MACK: begin
               // acknowledge high byte, refuse after low byte
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = 1'b0;
                     rel_nxt = (step_r == eeprom_pkg::STEP_LO);
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: scl_nxt = 1'b1;
                  default: begin
                     scl_nxt = 1'b0;
                     if (step_r == eeprom_pkg::STEP_HI) begin
                        rhi_nxt = sh_r;
                        step_nxt = eeprom_pkg::STEP_LO;
                        bc_nxt = eeprom_pkg::BIT_FIRST;
                        st_nxt = eeprom_pkg::XF_RBIT;
                     end else begin
                        st_nxt = eeprom_pkg::XF_STOP;
                     end
                  end
               endcase
            end
            eeprom_pkg::XF_STOP: begin
               // data rises while clock is high
               case (q_r)
                  eeprom_pkg::Q0: begin
                     scl_nxt = 1'b0;
                     rel_nxt = 1'b0;
                  end
                  eeprom_pkg::Q1: scl_nxt = 1'b1;
                  eeprom_pkg::Q2: rel_nxt = 1'b1;
                  default: begin
                     // R11 finish access
                     done_ev = 1'b1;
                     // R10 load only after a clean read
                     ld_ev = (cmd_r != eeprom_pkg::CMD_WRITE) && !nack_r;
                     st_nxt = eeprom_pkg::XF_IDLE;
                  end
               endcase
            end
            default: st_nxt = eeprom_pkg::XF_IDLE;
         endcase
      end
   end

   // serial engine flops
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= eeprom_pkg::XF_IDLE;
         q_r <= eeprom_pkg::Q0;
         bc_r <= eeprom_pkg::BIT_FIRST;
         step_r <= eeprom_pkg::STEP_CTRL;
         sh_r <= 8'h00;
         rhi_r <= 8'h00;
         nack_r <= 1'b0;
         scl_r <= 1'b1;
         rel_r <= 1'b1;
         sda_out_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         q_r <= q_nxt;
         bc_r <= bc_nxt;
         step_r <= step_nxt;
         sh_r <= sh_nxt;
         rhi_r <= rhi_nxt;
         nack_r <= nack_nxt;
         scl_r <= scl_nxt;
         rel_r <= rel_nxt;
         sda_out_r <= 1'b0; // open drain only ever pulls low
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign RDATA = rdata_r;
   assign IRQ = irq_r;
   assign EE_SCL = scl_r;
   assign EE_SDA_OUT = sda_out_r;
   assign EE_SDA_OE_N = rel_r;
   assign AUTOLOAD_ENABLE = aen_r;
endmodule // eeprom_access_port
`default_nettype wire

//--- core/eeprom_pkg.sv
// constants, register map and state codes of the eeprom access port
package eeprom_pkg;
   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_ACCESS = 8'hBC;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'hF0;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'hF4;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'hF8;
   // ----------------------------------------------------------------
   // access register field layout
   // ----------------------------------------------------------------
   localparam int START_BIT = 0;
   localparam int CMD_BIT = 1;
   localparam int ERR_BIT = 2;
   localparam int ALOAD_OK_BIT = 3;
   localparam int ALOAD_STAT_BIT = 4;
   localparam int ALOAD_DIS_BIT = 5;
   localparam int RATE_LSB = 6;
   localparam int RATE_MSB = 7;
   localparam int RSVD_BIT = 8;
   localparam int LOC_LSB = 9;
   localparam int LOC_MSB = 15;
   localparam int DATA_LSB = 16;
   localparam int DATA_MSB = 31;
   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic ALOAD_DIS_RST = 1'b1;
   localparam logic [1:0] RATE_RST = 2'h1;
   localparam logic [1:0] RATE_TEST = 2'h3;
   localparam logic [6:0] LOC_RST = 7'h00;
   localparam logic [15:0] DATA_RST = 16'h0000;
   localparam logic CMD_WRITE = 1'b1;
   // ----------------------------------------------------------------
   // serial clock timing: four quarter phases per serial clock period
   // ----------------------------------------------------------------
   localparam int CORE_CLK_MHZ = 125;
   localparam int SCL_DIV_NORMAL = 1024;
   localparam int SCL_DIV_TEST = 16;
   localparam int QUARTERS = 4;
   localparam logic [7:0] QTR_NORMAL_M1 = 8'(SCL_DIV_NORMAL / QUARTERS - 1);
   localparam logic [7:0] QTR_TEST_M1 = 8'(SCL_DIV_TEST / QUARTERS - 1);
   localparam logic [1:0] Q0 = 2'h0;
   localparam logic [1:0] Q1 = 2'h1;
   localparam logic [1:0] Q2 = 2'h2;
   localparam logic [1:0] Q3 = 2'h3;
   localparam logic [2:0] BIT_FIRST = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h0;
   // serial device select, value is arbitrary
   localparam logic [6:0] DEV_SEL = 7'h50;
   // ----------------------------------------------------------------
   // byte sequence steps of one access
   // ----------------------------------------------------------------
   localparam logic [2:0] STEP_CTRL = 3'h0;
   localparam logic [2:0] STEP_ADDR = 3'h1;
   localparam logic [2:0] STEP_DHI = 3'h2;
   localparam logic [2:0] STEP_DLO = 3'h3;
   localparam logic [2:0] STEP_CTRLR = 3'h4;
   localparam logic [2:0] STEP_HI = 3'h5;
   localparam logic [2:0] STEP_LO = 3'h6;
   // ----------------------------------------------------------------
   // interrupt bits
   // ----------------------------------------------------------------
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_ALOAD = 2;
   // ----------------------------------------------------------------
   // serial engine states
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      XF_IDLE = 8'h01,
      XF_START = 8'h02,
      XF_BIT = 8'h04,
      XF_ACK = 8'h08,
      XF_RBIT = 8'h10,
      XF_MACK = 8'h20,
      XF_RSTART = 8'h40,
      XF_STOP = 8'h80
   } xfer_e;
endpackage

//--- core/eeprom_qtr_tick.sv
// quarter-phase tick generator for the serial clock
`timescale 1ns/1ns
`default_nettype none
module eeprom_qtr_tick (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [1:0] rate,
   output logic tick
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic [7:0] reload;

   // count down, reload at zero; test mode runs fast
   always_comb begin
      reload = (rate == eeprom_pkg::RATE_TEST) ? eeprom_pkg::QTR_TEST_M1
                                              : eeprom_pkg::QTR_NORMAL_M1;
      tick = (cnt_r == 8'h00);
      if (tick || (cnt_r > reload)) begin
         cnt_nxt = reload;
      end else begin
         cnt_nxt = cnt_r - 8'h01;
      end
   end

   // counter register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= eeprom_pkg::QTR_NORMAL_M1;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // eeprom_qtr_tick
`default_nettype wire

//--- core/eeprom_rst_sync.sv
// two-stage release synchroniser for the asynchronous reset
`timescale 1ns/1ns
`default_nettype none
module eeprom_rst_sync (
   input wire logic clk,
   input wire logic rst_n,
   output logic rst_sync_n
);
   logic meta_r;
   logic meta_nxt;
   logic hold_r;
   logic hold_nxt;

   // next values: shift a one in after release
   always_comb begin
      meta_nxt = 1'b1;
      hold_nxt = meta_r;
   end

   // assert at once, release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign rst_sync_n = hold_r;
endmodule // eeprom_rst_sync
`default_nettype wire

//--- verification/eeprom_access_port_props.sv
// pin-level assertions of the eeprom access port
`timescale 1ns/1ns
`default_nettype none
module eeprom_access_port_props (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic EE_SCL,
   input wire logic EE_SDA_OUT,
   input wire logic AUTOLOAD_DONE,
   input wire logic AUTOLOAD_OK,
   input wire logic AUTOLOAD_ENABLE
);
   logic ld;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // loader success seen by the port
   assign ld = AUTOLOAD_DONE && AUTOLOAD_OK && AUTOLOAD_ENABLE;
   sequence rd_bc;
      RD && ADDR == 8'hBC;
   endsequence
   a_rdata_idle: assert property (!RD |=> RDATA == 32'h0)
      else $error("read data not idle");
   a_unmapped_zero: assert property (RD && !(ADDR inside {8'hBC, 8'hF0, 8'hF8})
      |=> RDATA == 32'h0) else $error("unmapped read not zero");
   a_reserved_zero: assert property (rd_bc |=> !RDATA[8]) else $error("bit 8 set");
   a_sda_open: assert property (!EE_SDA_OUT) else $error("data pin driven high");
   a_scl_hold: assert property ($changed(EE_SCL) |=> $stable(EE_SCL) [*3])
      else $error("serial clock too fast");
   a_enable_follow: assert property (rd_bc |=> AUTOLOAD_ENABLE == !RDATA[5])
      else $error("autoload enable mismatch");
   a_aload_sets: assert property (ld ##2 rd_bc |=> RDATA[4:3] == 2'h3)
      else $error("autoload bits not set");
   a_okbit_clears: assert property ((rd_bc ##0 !ld) ##1 !ld ##1 rd_bc |=> !RDATA[3])
      else $error("success bit not cleared");
   a_status_sticky: assert property (rd_bc ##1 RDATA[4] ##1 rd_bc |=> RDATA[4])
      else $error("status bit lost");
   a_idle_scl: assert property (rd_bc ##1 !RDATA[0] |-> EE_SCL)
      else $error("serial clock not idle");
endmodule // eeprom_access_port_props
bind eeprom_access_port eeprom_access_port_props props (.CLK(CLK), .RST_N(RST_N),
   .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .EE_SCL(EE_SCL), .EE_SDA_OUT(EE_SDA_OUT),
   .AUTOLOAD_DONE(AUTOLOAD_DONE), .AUTOLOAD_OK(AUTOLOAD_OK),
   .AUTOLOAD_ENABLE(AUTOLOAD_ENABLE));
`default_nettype wire

//--- verification/eeprom_slave_model.sv
// behavioural two-wire serial eeprom on the far side of the port
`timescale 1ns/1ns
`default_nettype none
module eeprom_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack,
   input wire logic [15:0] word,
   output logic pull,
   output logic [23:0] got
);
   logic [7:0] sh;
   logic [15:0] w;
   logic rd = 1'b0;
   logic first = 1'b0;
   int n = 0;
   initial pull = 1'b0;
   // start condition restarts the byte count
   always @(negedge sda) begin
      if (scl) begin
         n = 0;
         first = 1'b1;
         rd = 1'b0;
         w = word;
      end
   end
   // sample on rising clock; a master nack ends the read
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      if (n == 8 && rd && sda)
         rd = 1'b0;
      n = n + 1;
   end
   // change the drive only on the falling clock edge
   always @(negedge scl) begin
      pull = 1'b0;
      if (n == 9)
         n = 0;
      if (n == 8 && !rd) begin
         pull = !nack;
         got = {got[15:0], sh};
         rd = first && sh[0];
         first = 1'b0;
      end
      if (rd && n < 8) begin
         pull = !w[15];
         w = {w[14:0], w[15]};
      end
   end
endmodule // eeprom_slave_model
`default_nettype wire

//--- verification/tb_eeprom_access_port.sv
// self-checking bench of the eeprom access port
`timescale 1ns/1ns
`default_nettype none
module tb_eeprom_access_port;
   localparam logic [7:0] AW = eeprom_pkg::OFS_ACCESS;
   logic CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, rd_d = 1'b0, nack = 1'b0;
   logic AUTOLOAD_DONE = 1'b0, AUTOLOAD_OK = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, seed = 32'hCA9D3B01, RDATA;
   logic [15:0] word = 16'h0;
   logic [23:0] got;
   logic IRQ, EE_SCL, EE_SDA_OUT, EE_SDA_OE_N, AUTOLOAD_ENABLE, pull, sda;
   logic [31:0] q[$];
   int err_total = 0, samples_checked = 0;
   always #4 CLK = !CLK;
   // open-drain data line with pull-up
   assign sda = !(pull || !EE_SDA_OE_N);
   eeprom_access_port dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .EE_SCL(EE_SCL), .EE_SDA_IN(sda),
      .EE_SDA_OUT(EE_SDA_OUT), .EE_SDA_OE_N(EE_SDA_OE_N), .AUTOLOAD_DONE(AUTOLOAD_DONE),
      .AUTOLOAD_OK(AUTOLOAD_OK), .AUTOLOAD_ENABLE(AUTOLOAD_ENABLE));
   eeprom_slave_model mem (.scl(EE_SCL), .sda(sda), .nack(nack), .word(word), .pull(pull),
      .got(got));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic strobe(logic [7:0] a);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      strobe(a);
      q.push_back(e);
   endtask
   // poll until the start bit drops, bounded
   task automatic poll();
      int i;
      for (i = 0; i < 3000; i++) begin
         strobe(AW);
         @(negedge CLK);
         if (RDATA[0] === 1'b0)
            break;
      end
      if (i == 3000) begin
         cmp("poll bound", 32'h0, 32'h1);
         print_verdict();
      end
   endtask
   // compare each read answer with the oldest note
   always @(negedge CLK) begin
      if (rd_d && q.size() > 0)
         cmp("read word", q.pop_front(), RDATA);
      rd_d <= RD;
   end
   // main sequence
   initial begin
      logic [6:0] l;
      logic [15:0] d;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      rd(AW, 32'h60);
      rd(8'h10, 32'h0);
      wr(AW, 32'hC0);
      wr(eeprom_pkg::OFS_IRQ_ENABLE, 32'h7);
      @(posedge CLK);
      AUTOLOAD_DONE <= 1'b1;
      AUTOLOAD_OK <= 1'b1;
      @(posedge CLK);
      AUTOLOAD_DONE <= 1'b0;
      rd(AW, 32'hD8);
      rd(AW, 32'hD0);
      cmp("irq", 32'h1, {31'h0, IRQ});
      wr(eeprom_pkg::OFS_IRQ_ENABLE, 32'h2);
      wr(eeprom_pkg::OFS_IRQ_CLEAR, 32'h7);
      // write, read, then write refused by the memory
      for (int k = 0; k < 3; k++) begin
         l = 7'(xs());
         d = 16'(xs());
         word = ~d;
         nack = k == 2;
         wr(AW, {d, l, 1'b0, 6'h30, k != 1, 1'b1});
         wr(AW, 32'h0);
         poll();
         rd(AW, {(k == 1) ? ~d : d, l, 1'b0, 5'h1A, k == 2, k != 1, 1'b0});
         cmp("irq", {31'h0, k == 2}, {31'h0, IRQ});
         if (k == 0)
            cmp("wire bytes", {8'h0, l, 1'b0, d}, {8'h0, got});
      end
      wr(eeprom_pkg::OFS_IRQ_CLEAR, 32'h7);
      @(posedge CLK);
      @(negedge CLK);
      cmp("irq", 32'h0, {31'h0, IRQ});
      print_verdict();
   end
endmodule // tb_eeprom_access_port
`default_nettype wire
